// File: rtl/rpm_pin_mux.sv
// Contract
// - after reset every pin carries its primary function and an alternate appears only once software selects it.
// - while the reset pin is low the chip is held in reset.
// - the internal reset is released synchronously after a fixed count of clock cycles once the pin is released.
// - with the reset pin in general-purpose mode only power-on, watchdog or software reset reset the chip.
// - the reset pin in general-purpose mode is an input or an open-drain output, never driven high.
// - the reset pin returns to its reset function after any reset.
// - each general-purpose port pin is an input or an output by its own direction bit.
// - five port pins here can each carry one motor-drive output and then drive it unless a masked fault releases them.
// - an asserted fault input on a fault-configured pin disables the selected motor-drive outputs.
// - timer and fault alternates are chosen by chip configuration module selections.
// - timer channel two and fault input 1 can alternatively route to second-port pins.
`timescale 1ns/100ps
`default_nettype none
module rpm_pin_mux (
    input  wire logic                ref_clk_in,
    input  wire logic                rst_in,            // power-on reset, async
    input  wire logic                watchdog_reset_in,
    input  wire logic                soft_reset_in,
    // reset pin, three signals
    input  wire logic                reset_pin_in,
    output logic                     reset_pin_out,
    output logic                     reset_pin_oe_n_out,
    // chip configuration module selections
    input  wire logic                cfg_reset_pin_gpio_in,
    input  wire logic [9:0]          cfg_pin_fn_in,     // 2 bits per port bit 0..4
    input  wire logic [1:0]          cfg_timer_route_in,
    input  wire logic [1:0]          cfg_fault_route_in,
    input  wire logic [4:0]          cfg_fault_mask_in, // drive outputs gated by fault
    // general-purpose port control
    input  wire logic [5:0]          gpio_dir_in,       // bit 5 = reset pin bit
    input  wire logic [5:0]          gpio_data_in,
    output logic      [5:0]          gpio_read_out,
    // peripherals
    input  wire logic [4:0]          motor_drive_in,
    input  wire logic                timer_a_channel_two_in,
    input  wire logic                timer_a_channel_two_oe_in,
    output logic                     timer_a_channel_two_out,
    output logic                     external_fault_in_1_out,
    // port A bits 0..4
    input  wire logic [4:0]          port_first_pin_in,
    output logic      [4:0]          port_first_pin_out,
    output logic      [4:0]          port_first_pin_oe_n_out,
    output logic      [4:0]          port_first_pullup_out,
    // second-port alternates
    input  wire logic                port_second_bit_4_in,
    input  wire logic                port_second_b2_in,
    output logic                     port_second_b2_out,
    output logic                     port_second_b2_oe_n_out,
    // chip reset
    output logic                     chip_reset_out
);
    import rpm_pkg::*;

    // ************************************************************
    // notes for users
    // ************************************************************
    // every pad input, the second-port timer pin included, passes a three-stage
    // synchroniser; a level only counts once stages two and three agree, so a
    // glitch shorter than one clock never reaches the peripherals.
    // the reset pin is only a reset source in its primary function; once the
    // pin is general purpose a low level on it is just data.
    // the general-purpose choice for the reset pin is ignored while the chip
    // reset is active and is taken up again from the selection once it drops.
    // the reset pin is never driven high: it is released or pulled low only.
    // pin selections other than the fault routing are honoured only once the chip reset has dropped; until
    // then every port pin is an input with its pull-up on.
    // limitation: a selection change reaches the pads one clock later; the reset pin's general-purpose choice takes two.

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [2:0]               rpin_sync;
        logic [2:0]               fault_sync;
        logic [5:0][2:0]          pin_sync;
        logic                     rpin_low;
        logic [RPM_RST_CNT_W-1:0] hold_cnt;
        logic                     chip_reset;
        logic                     gpio_mode;
        logic                     rpin_out;
        logic                     rpin_oe_n;
        logic [4:0]               pa_out;
        logic [4:0]               pa_oe_n;
        logic [4:0]               pa_pu;
        logic [5:0]               rd;
        logic                     ta2_in;
        logic                     f1;
        logic                     b2_out;
        logic                     b2_oe_n;
        logic [2:0]               b2_sync;
    } rpm_state_t;

    rpm_state_t st;
    rpm_state_t next_st;
    logic [5:0] pin_raw;
    logic       fault_raw;
    logic       fault_now;
    logic [1:0] fn;

    assign pin_raw = {reset_pin_in, port_first_pin_in};
    // fault source follows the routing choice
    assign fault_raw = (cfg_fault_route_in == RPM_ROUTE_SECOND) ? port_second_bit_4_in
                     : port_first_pin_in[RPM_SHARED_BIT];

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        next_st = st;
        fn      = RPM_FN_GPIO;
        // three-stage synchronisers; a change counts when stages 2 and 3 agree
        next_st.rpin_sync  = {st.rpin_sync[1:0], reset_pin_in};
        next_st.fault_sync = {st.fault_sync[1:0], fault_raw};
        for (int i = 0; i < 6; i++) begin
            next_st.pin_sync[i] = {st.pin_sync[i][1:0], pin_raw[i]};
            if (st.pin_sync[i][2] == st.pin_sync[i][1]) begin
                next_st.rd[i] = st.pin_sync[i][2];
            end
        end
        if (st.rpin_sync[2] == st.rpin_sync[1]) begin
            next_st.rpin_low = ~st.rpin_sync[2];
        end
        if (st.fault_sync[2] == st.fault_sync[1]) begin
            fault_now = st.fault_sync[2];
        end else begin
            fault_now = st.f1;
        end
        next_st.f1 = fault_now;
        // gpio mode is taken only while out of reset; reset clears it
        next_st.gpio_mode = cfg_reset_pin_gpio_in && !st.chip_reset;
        // reset pin as reset source only in its primary function
        if ((st.rpin_low && !st.gpio_mode) || watchdog_reset_in || soft_reset_in) begin
            next_st.chip_reset = 1'b1;
            next_st.hold_cnt   = '0;
            next_st.gpio_mode  = 1'b0;
        end else if (st.chip_reset) begin
            // counted release keeps reset removal on a clock edge
            if (st.hold_cnt == RPM_RST_CNT_W'(RPM_RST_HOLD_CYCLES - 1)) begin
                next_st.chip_reset = 1'b0;
            end else begin
                next_st.hold_cnt = st.hold_cnt + 1'b1;
            end
        end
        // reset pin gpio: drive low only, otherwise released
        next_st.rpin_out  = 1'b0;
        next_st.rpin_oe_n = ~(st.gpio_mode && gpio_dir_in[5] && !gpio_data_in[5]);
        // port A bits
        for (int i = 0; i < RPM_PORT_BITS; i++) begin
            fn = st.chip_reset ? RPM_FN_GPIO : cfg_pin_fn_in[2*i +: 2];
            next_st.pa_pu[i]   = 1'b0;
            next_st.pa_out[i]  = gpio_data_in[i];
            next_st.pa_oe_n[i] = ~gpio_dir_in[i] | st.chip_reset;
            if (fn == RPM_FN_GPIO) begin
                next_st.pa_pu[i] = ~gpio_dir_in[i] | st.chip_reset;
            end else if (fn == RPM_FN_DRIVE) begin
                next_st.pa_out[i]  = motor_drive_in[i];
                next_st.pa_oe_n[i] = fault_now && cfg_fault_mask_in[i];
            end else if (fn == RPM_FN_TIMER && i == RPM_SHARED_BIT
                         && cfg_timer_route_in == RPM_ROUTE_PORTA) begin
                next_st.pa_out[i]  = timer_a_channel_two_in;
                next_st.pa_oe_n[i] = ~timer_a_channel_two_oe_in;
            end else begin
                next_st.pa_oe_n[i] = 1'b1;                                  // fault input
            end
        end
        // timer channel two routing to second port; its pad is synchronised too
        next_st.b2_sync = {st.b2_sync[1:0], port_second_b2_in};
        if (cfg_timer_route_in == RPM_ROUTE_SECOND && !st.chip_reset) begin
            next_st.b2_out  = timer_a_channel_two_in;
            next_st.b2_oe_n = ~timer_a_channel_two_oe_in;
            if (st.b2_sync[2] == st.b2_sync[1]) begin
                next_st.ta2_in = st.b2_sync[2];
            end
        end else begin
            next_st.b2_out  = 1'b0;
            next_st.b2_oe_n = 1'b1;
            next_st.ta2_in  = st.rd[RPM_SHARED_BIT];
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st            <= '0;
            st.chip_reset <= 1'b1;
            st.rpin_oe_n  <= 1'b1;
            st.pa_oe_n    <= 5'h1F;
            st.pa_pu      <= RPM_PU_RESET;
            st.b2_oe_n    <= 1'b1;
            st.rpin_sync  <= 3'h7;
            st.pin_sync   <= '1;
            st.rd         <= 6'h3F;
        end else begin
            st <= next_st;
        end
    end

    assign reset_pin_out           = st.rpin_out;
    assign reset_pin_oe_n_out      = st.rpin_oe_n;
    assign gpio_read_out           = st.rd;
    assign timer_a_channel_two_out = st.ta2_in;
    assign external_fault_in_1_out = st.f1;
    assign port_first_pin_out      = st.pa_out;
    assign port_first_pin_oe_n_out = st.pa_oe_n;
    assign port_first_pullup_out   = st.pa_pu;
    assign port_second_b2_out      = st.b2_out;
    assign port_second_b2_oe_n_out = st.b2_oe_n;
    assign chip_reset_out          = st.chip_reset;
endmodule // rpm_pin_mux
`default_nettype wire

// File: include/rpm_pkg.sv
`default_nettype none
package rpm_pkg;
    // pin function selects for port A bits 0..4
    localparam logic [1:0] RPM_FN_GPIO  = 2'h0;
    localparam logic [1:0] RPM_FN_DRIVE = 2'h1;
    localparam logic [1:0] RPM_FN_TIMER = 2'h2;
    localparam logic [1:0] RPM_FN_FAULT = 2'h3;
    // routing of timer channel two / fault input 1
    localparam logic [1:0] RPM_ROUTE_PORTA  = 2'h0;
    localparam logic [1:0] RPM_ROUTE_SECOND = 2'h1;
    // internal reset release delay
    localparam int RPM_RST_HOLD_CYCLES = 32;
    localparam int RPM_RST_CNT_W       = 6;
    // reset values
    localparam logic [4:0] RPM_DIR_RESET = 5'h00;
    localparam logic [4:0] RPM_PU_RESET  = 5'h1F;
    // index of the pin carrying the shared timer/fault alternates
    localparam int RPM_SHARED_BIT = 4;
    localparam int RPM_PORT_BITS  = 5;
endpackage : rpm_pkg
`default_nettype wire

// File: testbench/rpm_pin_mux_sva.sv
`timescale 1ns/100ps
`default_nettype none
module rpm_pin_mux_sva (
    input wire logic ref_clk_in, rst_in, watchdog_reset_in, soft_reset_in, reset_pin_in,
    input wire logic reset_pin_out, reset_pin_oe_n_out, chip_reset_out,
    input wire logic cfg_reset_pin_gpio_in, external_fault_in_1_out,
    input wire logic [9:0] cfg_pin_fn_in,
    input wire logic [4:0] cfg_fault_mask_in, motor_drive_in, port_first_pin_out,
    input wire logic [4:0] port_first_pin_oe_n_out,
    input wire logic [5:0] gpio_dir_in, gpio_data_in
);
    import rpm_pkg::*;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    logic [7:0] quiet;
    // edges since the last reset cause went away
    always_ff @(posedge ref_clk_in or posedge rst_in)
        if (rst_in || watchdog_reset_in || soft_reset_in || !reset_pin_in) quiet <= 8'h00;
        else if (quiet != 8'hFF) quiet <= quiet + 8'h01;
    // running two edges, so selections are honoured
    sequence s_run; !chip_reset_out [*2]; endsequence
    a_pin_not_high: assert property (!reset_pin_out)
        else $error("pin high");
    a_release_gap: assert property ($fell(chip_reset_out) |-> quiet inside {[31:37]})
        else $error("release gap");
    a_pin_resets: assert property ((!cfg_reset_pin_gpio_in && !reset_pin_in) [*6]
        |-> chip_reset_out) else $error("pin reset");
    a_pin_ignored: assert property (!chip_reset_out && cfg_reset_pin_gpio_in
        && !watchdog_reset_in && !soft_reset_in |=> !chip_reset_out) else $error("pin reset");
    a_pin_released: assert property (chip_reset_out [*2] |-> reset_pin_oe_n_out)
        else $error("pin driven");
    a_drive_path: assert property (s_run ##0 cfg_pin_fn_in[1:0] == RPM_FN_DRIVE
        && !cfg_fault_mask_in[0] |=> !port_first_pin_oe_n_out[0]
        && port_first_pin_out[0] == $past(motor_drive_in[0])) else $error("drive");
    a_fault_gate: assert property ((!chip_reset_out && external_fault_in_1_out
        && cfg_fault_mask_in[0] && cfg_pin_fn_in == 10'h301) [*2]
        |-> ##[0:2] port_first_pin_oe_n_out[0]) else $error("fault");
    a_dir_bit: assert property (s_run ##0 cfg_pin_fn_in[3:2] == RPM_FN_GPIO |=>
        port_first_pin_oe_n_out[1] == !$past(gpio_dir_in[1]) && (port_first_pin_oe_n_out[1]
        || port_first_pin_out[1] == $past(gpio_data_in[1]))) else $error("dir");
    a_open_drain: assert property (s_run ##0 cfg_reset_pin_gpio_in
        && $past(cfg_reset_pin_gpio_in) |=>
        reset_pin_oe_n_out == !($past(gpio_dir_in[5]) && !$past(gpio_data_in[5])))
        else $error("open drain");
endmodule // rpm_pin_mux_sva
bind rpm_pin_mux rpm_pin_mux_sva u_sva (.ref_clk_in, .rst_in, .watchdog_reset_in,
    .soft_reset_in, .reset_pin_in, .reset_pin_out, .reset_pin_oe_n_out, .chip_reset_out,
    .cfg_reset_pin_gpio_in, .external_fault_in_1_out, .cfg_pin_fn_in, .cfg_fault_mask_in,
    .motor_drive_in, .port_first_pin_out, .port_first_pin_oe_n_out, .gpio_dir_in,
    .gpio_data_in);
`default_nettype wire

// File: testbench/rpm_board.sv
`timescale 1ns/100ps
`default_nettype none
module rpm_board (
    input  wire logic       rst_low_in,
    input  wire logic       rst_oe_n_in,
    input  wire logic [4:0] pin_in, oe_n_in, pu_in, en_in, val_in,
    output logic            rst_pad_out,
    output logic      [4:0] pad_out
);
    // reset line is open drain with a pull-up: only a low is ever driven
    assign rst_pad_out = !(rst_low_in || !rst_oe_n_in);
    // chip, then board, then pull-up; a floating pad shows the inverse of the
    // last chip value so a missing pull-up cannot hide behind a lucky level
    assign pad_out = (~oe_n_in & pin_in) | (oe_n_in & en_in & val_in)
                   | (oe_n_in & ~en_in & (pu_in | ~pin_in));
endmodule // rpm_board
`default_nettype wire

// File: testbench/tb_rpm_pin_mux.sv
`timescale 1ns/100ps
`default_nettype none
module tb_rpm_pin_mux;
    typedef struct packed {logic [9:0] fn; logic [5:0] dir, dat; logic [4:0] drv, oe, val;} rpm_row_t;
    logic clk, rst, wd, sw, prst, gsel, tin, toe, alt4, rpo, rpoe, crst, tout, fout, b2o, b2oe, rpad;
    logic b2in;
    logic [9:0] fn;
    logic [1:0] trt, frt;
    logic [5:0] dir, dat, rd;
    logic [4:0] mask, drv, ben, bval, po, poe, ppu, pad;
    int n_fail, num_checks, cycles, n;
    rpm_row_t rows [4];
    rpm_pin_mux u_dut (.ref_clk_in(clk), .rst_in(rst), .watchdog_reset_in(wd),
        .soft_reset_in(sw), .reset_pin_in(rpad), .reset_pin_out(rpo), .reset_pin_oe_n_out(rpoe),
        .cfg_reset_pin_gpio_in(gsel), .cfg_pin_fn_in(fn), .cfg_timer_route_in(trt),
        .cfg_fault_route_in(frt), .cfg_fault_mask_in(mask), .gpio_dir_in(dir),
        .gpio_data_in(dat), .gpio_read_out(rd), .motor_drive_in(drv), .timer_a_channel_two_in(tin),
        .timer_a_channel_two_oe_in(toe), .timer_a_channel_two_out(tout),
        .external_fault_in_1_out(fout), .port_first_pin_in(pad), .port_first_pin_out(po),
        .port_first_pin_oe_n_out(poe), .port_first_pullup_out(ppu), .port_second_bit_4_in(alt4),
        .port_second_b2_in(b2in), .port_second_b2_out(b2o), .port_second_b2_oe_n_out(b2oe),
        .chip_reset_out(crst));
    rpm_board u_board (.rst_low_in(prst), .rst_oe_n_in(rpoe), .pin_in(po), .oe_n_in(poe),
        .pu_in(ppu), .en_in(ben), .val_in(bval), .rst_pad_out(rpad), .pad_out(pad));
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [4:0] e, input logic [4:0] s);
        num_checks++;
        if (s !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, s);
            n_fail++;
        end
    endtask
    // wait for chip reset to drop, bounded so a stuck reset still ends the run
    task automatic settle;
        for (n = 0; crst !== 1'b0 && n < 80; n++) cyc(1);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    // hang guard: the run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    initial begin
        {wd, sw, prst, gsel, tin, toe, alt4, b2in, fn, trt, frt, dir, dat, mask, drv, ben, bval} = '0;
        rst = 1;
        rows = '{'{10'h000, 6'h00, 6'h00, 5'h00, 5'h1F, 5'h00}, '{10'h000, 6'h1F, 6'h15, 5'h00,
            5'h00, 5'h15}, '{10'h155, 6'h00, 6'h00, 5'h0A, 5'h00, 5'h0A}, '{10'h001, 6'h02,
            6'h02, 5'h1F, 5'h1C, 5'h03}};
        cyc(16);
        chk("held", 5'h01, 5'(crst));
        chk("pad oe", 5'h1F, poe);
        chk("pullups", 5'h1F, ppu);
        rst = 0;
        settle();
        chk("release gap", 5'h01, 5'(n >= 31 && n <= 34));
        foreach (rows[i]) begin
            {fn, dir, dat, drv} = {rows[i].fn, rows[i].dir, rows[i].dat, rows[i].drv};
            cyc(2);
            chk("pad oe", rows[i].oe, poe);
            chk("pad level", rows[i].val, pad & ~rows[i].oe);
        end
        {fn, dir, mask, drv, ben, bval} = {10'h301, 6'h00, 5'h01, 5'h01, 5'h10, 5'h10};
        cyc(8);
        chk("fault gate", 5'h03, 5'({fout, poe[0]}));
        bval = 5'h00;
        cyc(8);
        chk("fault clear", 5'h00, 5'({fout, poe[0]}));
        {frt, alt4} = 3'h3;
        cyc(8);
        chk("fault alt", 5'h01, 5'(fout));
        {fn, ben, alt4, tin, toe} = {10'h200, 5'h00, 3'h3};
        cyc(3);
        chk("timer pad", 5'h01, 5'({poe[4], po[4]}));
        {trt, b2in} = 3'h3;
        cyc(3);
        chk("timer alt", 5'h01, 5'({b2oe, b2o}));
        cyc(3);
        chk("timer in", 5'h01, 5'(tout));
        {fn, gsel, dir, dat} = {10'h000, 1'b1, 6'h20, 6'h20};
        cyc(3);
        chk("pin off", 5'h01, 5'(rpoe));
        dat = 6'h00;
        cyc(8);
        chk("pin low", 5'h00, 5'({rpoe, rd[5], crst}));
        {wd, dat} = {1'b1, 6'h20};
        cyc(1);
        wd = 0;
        cyc(2);
        chk("watchdog", 5'h03, 5'({crst, rpoe}));
        settle();
        {gsel, prst} = 2'h1;
        cyc(6);
        chk("pin reset", 5'h01, 5'(crst));
        prst = 0;
        settle();
        sw = 1;
        cyc(1);
        sw = 0;
        cyc(2);
        chk("soft reset", 5'h01, 5'(crst));
        settle();
        chk("running", 5'h00, 5'(crst));
        tally_and_finish();
    end
endmodule // tb_rpm_pin_mux
`default_nettype wire
